// File: design/dsf_field.sv
// Per-field detection and clear counter
`timescale 1ns/1ps
`default_nettype none
module dsf_field (
    input  wire logic mclk,
    input  wire logic rst_b,
    dsf_field_if.field fld
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [dsf_pkg::CNT_W-1:0] det_cnt;  // Successive detections
        logic [dsf_pkg::CNT_W-1:0] clr_cnt;  // Successive clear scans
        logic                      tripped;  // Shutdown held
        logic                      after_sw; // Switch count in force
    } dsf_fld_s;

    dsf_fld_s st_q;  // Registered state
    dsf_fld_s st_d;  // Next state

    logic [dsf_pkg::CNT_W-1:0] req;      // Count in force this scan
    logic                      aft;      // Switch window after pulse

    // ==========================================================
    // Next state
    // ==========================================================
    // A switch pulse in the same cycle as a scan counts that scan
    // in the new case, so the switch count starts at once.
    always_comb begin
        st_d = st_q;
        aft  = st_q.after_sw;
        if (fld.sw) begin
            st_d.det_cnt  = dsf_pkg::CNT_ZERO;
            st_d.after_sw = 1'b1;
            aft           = 1'b1;
        end
        req = aft ? fld.nsw_req : fld.n_req;
        if (fld.eval) begin
            if (!st_q.tripped) begin
                if (!fld.detect) begin
                    // A clear scan breaks the run and ends the window
                    st_d.det_cnt  = dsf_pkg::CNT_ZERO;
                    st_d.after_sw = 1'b0;
                end else if (st_d.det_cnt >= req - dsf_pkg::CNT_ONE) begin
                    // Enough detections: shut down
                    st_d.tripped  = 1'b1;
                    st_d.det_cnt  = dsf_pkg::CNT_ZERO;
                    st_d.clr_cnt  = dsf_pkg::CNT_ZERO;
                    st_d.after_sw = 1'b0;
                end else begin
                    // Keep counting; a bigger count means later trip
                    st_d.det_cnt = st_d.det_cnt + dsf_pkg::CNT_ONE;
                end
            end else begin
                if (fld.detect) begin
                    st_d.clr_cnt = dsf_pkg::CNT_ZERO;
                end else if (st_q.clr_cnt >= fld.clr_req - dsf_pkg::CNT_ONE)
                begin
                    st_d.tripped = 1'b0;
                    st_d.clr_cnt = dsf_pkg::CNT_ZERO;
                end else begin
                    st_d.clr_cnt = st_q.clr_cnt + dsf_pkg::CNT_ONE;
                end
            end
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Fields start tripped so nothing reads ON before clear scans
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.det_cnt  <= dsf_pkg::CNT_ZERO;
            st_q.clr_cnt  <= dsf_pkg::CNT_ZERO;
            st_q.tripped  <= dsf_pkg::TRIP_RESET;
            st_q.after_sw <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign fld.tripped = st_q.tripped;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_trip_on_count;
        @(posedge mclk) disable iff (!rst_b)
        fld.eval && !fld.sw && !st_q.tripped && fld.detect &&
        st_q.det_cnt == req - dsf_pkg::CNT_ONE |=> st_q.tripped;
    endproperty
    a_trip_on_count: assert property (p_trip_on_count)
        else $error("field did not trip at the sample count");

    property p_no_early_trip;
        @(posedge mclk) disable iff (!rst_b)
        $rose(st_q.tripped) |-> $past(fld.detect) && $past(fld.eval);
    endproperty
    a_no_early_trip: assert property (p_no_early_trip)
        else $error("field tripped without a detection");

    property p_break_restart;
        @(posedge mclk) disable iff (!rst_b)
        fld.eval && !st_q.tripped && !fld.detect |=> st_q.det_cnt == 0;
    endproperty
    a_break_restart: assert property (p_break_restart)
        else $error("detection count kept after a clear scan");

    property p_switch_restart;
        @(posedge mclk) disable iff (!rst_b)
        fld.sw && !fld.eval |=> st_q.det_cnt == 0 && st_q.after_sw;
    endproperty
    a_switch_restart: assert property (p_switch_restart)
        else $error("switch did not restart the detection count");

    property p_release;
        @(posedge mclk) disable iff (!rst_b)
        fld.eval && st_q.tripped && !fld.detect &&
        st_q.clr_cnt == fld.clr_req - dsf_pkg::CNT_ONE |=> !st_q.tripped;
    endproperty
    a_release: assert property (p_release)
        else $error("field not released after the clear count");

    property p_hold_on_detect;
        @(posedge mclk) disable iff (!rst_b)
        fld.eval && st_q.tripped && fld.detect
        |=> st_q.tripped && st_q.clr_cnt == 0;
    endproperty
    a_hold_on_detect: assert property (p_hold_on_detect)
        else $error("detection did not restart the clear count");

    c_trip: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(st_q.tripped));
    c_sw_trip: cover property (@(posedge mclk) disable iff (!rst_b)
        st_q.after_sw ##1 $rose(st_q.tripped));
endmodule
`default_nettype wire

// File: design/dsf_top.sv
// Detection sampling filter: control, count selection and outputs
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Trip after configured number of detections
// - Larger sample count delays the response
// - Switch count applies right after case switch
// - Fast setting: switch count is one
// - Reliable setting: normal count less one, min one
// - User setting capped at count less one
// - Four clear scans before outputs go ON
// - Optional per-field clear counts replace four
// - Global count unless field overrides it
module dsf_top #(
    parameter int NF = dsf_pkg::NUM_FIELDS  // Number of fields
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    input  wire logic                         scan_tick,
    input  wire logic                         case_switch,
    input  wire logic [NF-1:0]                detect,
    input  wire logic [dsf_pkg::CNT_W-1:0]    base_count,
    input  wire logic [NF-1:0]                ovr_en,
    input  wire logic [NF-1:0][dsf_pkg::CNT_W-1:0] ovr_count,
    input  wire dsf_pkg::dsf_sw_mode_e        sw_mode,
    input  wire logic [dsf_pkg::CNT_W-1:0]    user_sw_count,
    input  wire logic                         alt_clear_en,
    input  wire logic [NF-1:0][dsf_pkg::CNT_W-1:0] clear_count,
    output logic      [NF-1:0]                safety_on,
    output logic                              user_count_clamped
);
    // ==========================================================
    // Helpers
    // ==========================================================
    // Zero is not a usable count; treat it as one
    function automatic logic [dsf_pkg::CNT_W-1:0] floor1(
        input logic [dsf_pkg::CNT_W-1:0] x
    );
        floor1 = (x == dsf_pkg::CNT_ZERO) ? dsf_pkg::CNT_ONE : x;
    endfunction

    // Used for the reliable setting and as the user-count limit
    // One fewer than a count, never below one
    function automatic logic [dsf_pkg::CNT_W-1:0] less1(
        input logic [dsf_pkg::CNT_W-1:0] n
    );
        less1 = (n > dsf_pkg::CNT_ONE) ? n - dsf_pkg::CNT_ONE
                                       : dsf_pkg::CNT_ONE;
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [NF-1:0] on;       // Safety outputs, 1 = ON
        logic          clamped;  // Any field capped the user count
    } dsf_top_s;

    dsf_top_s st_q;  // Registered outputs
    dsf_top_s st_d;  // Next outputs

    logic [NF-1:0][dsf_pkg::CNT_W-1:0] n_eff;   // Normal count per field
    logic [NF-1:0][dsf_pkg::CNT_W-1:0] nsw_eff; // Switch count per field
    logic [NF-1:0][dsf_pkg::CNT_W-1:0] clr_eff; // Clear count per field
    logic [NF-1:0]                     cap_hit; // User count was cut
    logic [NF-1:0]                     trip_v;  // Field tripped flags

    // ==========================================================
    // Field counters
    // ==========================================================
    // Each field resolves its own counts, so overrides stay local
    // Every field sees the same scan and switch pulses
    generate
        for (genvar i = 0; i < NF; i++) begin : g_fld
            dsf_field_if fif ();

            // Field override beats the global count
            assign n_eff[i] = ovr_en[i] ? floor1(ovr_count[i])
                                        : floor1(base_count);

            // Switch count by setting
            always_comb begin
                cap_hit[i] = 1'b0;
                case (sw_mode)
                    dsf_pkg::DSF_SW_FAST: begin
                        nsw_eff[i] = dsf_pkg::CNT_ONE;
                    end
                    dsf_pkg::DSF_SW_RELIABLE: begin
                        nsw_eff[i] = less1(n_eff[i]);
                    end
                    dsf_pkg::DSF_SW_USER: begin
                        // Larger values are not accepted: cut to limit
                        if (floor1(user_sw_count) > less1(n_eff[i])) begin
                            nsw_eff[i] = less1(n_eff[i]);
                            cap_hit[i] = 1'b1;
                        end else begin
                            nsw_eff[i] = floor1(user_sw_count);
                        end
                    end
                    default: begin
                        nsw_eff[i] = dsf_pkg::CNT_ONE;
                    end
                endcase
            end

            // Clear count: fixed four unless alternate values enabled
            assign clr_eff[i] = alt_clear_en ? floor1(clear_count[i])
                                : dsf_pkg::CLEAR_DEFAULT;

            assign fif.eval    = scan_tick;
            assign fif.sw      = case_switch;
            assign fif.detect  = detect[i];
            assign fif.n_req   = n_eff[i];
            assign fif.nsw_req = nsw_eff[i];
            assign fif.clr_req = clr_eff[i];
            assign trip_v[i]   = fif.tripped;

            dsf_field u_fld (
                .mclk  (mclk),
                .rst_b (rst_b),
                .fld   (fif.field)
            );
        end
    endgenerate

    // ==========================================================
    // Output registers
    // ==========================================================
    // One register stage keeps outputs glitch free at the pins
    // Reset drives outputs OFF; the fields start tripped as well
    always_comb begin
        st_d         = st_q;
        st_d.on      = ~trip_v;
        st_d.clamped = (sw_mode == dsf_pkg::DSF_SW_USER) && (|cap_hit);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q.on      <= '0;
            st_q.clamped <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign safety_on          = st_q.on;
    assign user_count_clamped = st_q.clamped;

    // ==========================================================
    // Checks
    // ==========================================================
    // Only field 0 is checked in detail; the fields are identical
    property p_out_follow;
        @(posedge mclk) disable iff (!rst_b)
        1'b1 |=> safety_on == ~$past(trip_v);
    endproperty
    a_out_follow: assert property (p_out_follow)
        else $error("safety outputs do not follow field state");

    property p_fast_one;
        @(posedge mclk) disable iff (!rst_b)
        sw_mode == dsf_pkg::DSF_SW_FAST |-> nsw_eff[0] == 4'h1;
    endproperty
    a_fast_one: assert property (p_fast_one)
        else $error("fast switch count is not one");

    property p_reliable;
        @(posedge mclk) disable iff (!rst_b)
        sw_mode == dsf_pkg::DSF_SW_RELIABLE |->
        (n_eff[0] > 4'h1 ? nsw_eff[0] + 4'h1 == n_eff[0]
                         : nsw_eff[0] == 4'h1);
    endproperty
    a_reliable: assert property (p_reliable)
        else $error("reliable switch count is wrong");

    property p_user_cap;
        @(posedge mclk) disable iff (!rst_b)
        sw_mode == dsf_pkg::DSF_SW_USER |-> nsw_eff[0] >= 4'h1 &&
        (n_eff[0] > 4'h1 ? nsw_eff[0] < n_eff[0] : nsw_eff[0] == 4'h1);
    endproperty
    a_user_cap: assert property (p_user_cap)
        else $error("user switch count above limit");

    property p_clear_four;
        @(posedge mclk) disable iff (!rst_b)
        !alt_clear_en |-> clr_eff[0] == 4'h4;
    endproperty
    a_clear_four: assert property (p_clear_four)
        else $error("fixed clear count is not four");

    property p_override;
        @(posedge mclk) disable iff (!rst_b)
        ovr_en[0] && ovr_count[0] != 4'h0 |-> n_eff[0] == ovr_count[0];
    endproperty
    a_override: assert property (p_override)
        else $error("field override count not used");

    property p_clamp_mode;
        @(posedge mclk) disable iff (!rst_b)
        user_count_clamped |-> $past(sw_mode) == dsf_pkg::DSF_SW_USER;
    endproperty
    a_clamp_mode: assert property (p_clamp_mode)
        else $error("clamp flag raised outside the user setting");

    property p_alt_clear;
        @(posedge mclk) disable iff (!rst_b)
        alt_clear_en && clear_count[0] != 4'h0
        |-> clr_eff[0] == clear_count[0];
    endproperty
    a_alt_clear: assert property (p_alt_clear)
        else $error("alternate clear count not used");

    c_override: cover property (@(posedge mclk) disable iff (!rst_b)
        scan_tick && ovr_en[0] && detect[0]);

    c_release: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(safety_on[0]));
    c_clamp: cover property (@(posedge mclk) disable iff (!rst_b)
        $rose(user_count_clamped));
endmodule
`default_nettype wire

// File: shared/dsf_field_if.sv
// Interface between the filter control and one field counter
`timescale 1ns/1ps
`default_nettype none
interface dsf_field_if;
    logic                     eval;     // Scan evaluation enable pulse
    logic                     sw;       // Monitoring case switch pulse
    logic                     detect;   // Object seen in this scan
    logic [dsf_pkg::CNT_W-1:0] n_req;   // Normal sample count
    logic [dsf_pkg::CNT_W-1:0] nsw_req; // Sample count after a switch
    logic [dsf_pkg::CNT_W-1:0] clr_req; // Clear scans before ON
    logic                     tripped;  // Field holds shutdown

    // Control side drives configuration and scan data
    modport ctrl  (output eval, sw, detect, n_req, nsw_req, clr_req,
                   input  tripped);
    // Field side counts and reports its state
    modport field (input  eval, sw, detect, n_req, nsw_req, clr_req,
                   output tripped);
endinterface
`default_nettype wire

// File: shared/dsf_pkg.sv
// Package of constants and types for the detection sampling filter
`default_nettype none
package dsf_pkg;
    // ==========================================================
    // Counter widths and fixed counts
    // ==========================================================
    localparam int          CNT_W         = 4;     // Holds counts up to 15
    localparam logic [3:0]  CNT_ONE       = 4'h1;  // Least legal count
    localparam logic [3:0]  CNT_ZERO      = 4'h0;  // Counter restart value
    localparam logic [3:0]  CLEAR_DEFAULT = 4'h4;  // Clear scans, fixed mode
    localparam int          NUM_FIELDS    = 4;     // Default field count
    // Reset state of a field: tripped, so outputs start OFF
    localparam logic        TRIP_RESET    = 1'b1;

    // ==========================================================
    // Switch sample count settings
    // ==========================================================
    typedef enum logic [1:0] {
        DSF_SW_FAST,       // Switch count of one (default)
        DSF_SW_RELIABLE,   // Normal count less one
        DSF_SW_USER        // User value, capped at normal less one
    } dsf_sw_mode_e;
endpackage
`default_nettype wire

// File: verification/dsf_machine_ctrl.sv
// Machine control model that watches the field safety outputs
`timescale 1ns/1ps
`default_nettype none
module dsf_machine_ctrl #(
    parameter int NF = 4                   // Number of fields watched
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic [NF-1:0] safety_on,
    output logic               run_ok
);
    // ==========================================================
    // Motion permit
    // ==========================================================
    // Motion allowed only while every field is ON; one cycle late,
    // since a real control samples its inputs on its own cycle
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            run_ok <= 1'b0;
        end else begin
            run_ok <= &safety_on;
        end
    end
endmodule
`default_nettype wire

// File: verification/tb_detection_sampling_filter.sv
// Self-checking bench of the detection sampling filter
`timescale 1ns/1ps
`default_nettype none
module tb_detection_sampling_filter;
    // ==========================================================
    // Signals and table
    // ==========================================================
    logic mclk = 1'b0;                     // 50 MHz clock
    logic rst_b, scan_tick, case_switch, alt_clear_en;
    logic [3:0] detect, base_count, ovr_en, user_sw_count;
    logic [3:0][3:0] ovr_count, clear_count;
    dsf_pkg::dsf_sw_mode_e sw_mode;
    logic [3:0] safety_on;                 // Field outputs
    logic user_count_clamped, run_ok;
    int n_mismatch = 0;
    int comparisons = 0;
    // One row: count, mode, user count, switch first, scans, result
    typedef struct {
        logic [3:0] n;
        dsf_pkg::dsf_sw_mode_e m;
        logic [3:0] u;
        logic sw;
        int k;
        logic [3:0] e;
        logic c;
    } dsf_row_s;
    dsf_row_s rows[14] = '{
        '{4'h2, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 1, 4'hf, 1'b0},
        '{4'h2, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 2, 4'h0, 1'b0},
        '{4'h3, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 2, 4'hf, 1'b0},
        '{4'h3, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 3, 4'h0, 1'b0},
        '{4'h8, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 7, 4'hf, 1'b0},
        '{4'h8, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 8, 4'h0, 1'b0},
        '{4'h0, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b0, 1, 4'h0, 1'b0},
        '{4'h3, dsf_pkg::DSF_SW_FAST, 4'h0, 1'b1, 1, 4'h0, 1'b0},
        '{4'h3, dsf_pkg::DSF_SW_RELIABLE, 4'h0, 1'b1, 1, 4'hf, 1'b0},
        '{4'h3, dsf_pkg::DSF_SW_RELIABLE, 4'h0, 1'b1, 2, 4'h0, 1'b0},
        '{4'h1, dsf_pkg::DSF_SW_RELIABLE, 4'h0, 1'b1, 1, 4'h0, 1'b0},
        '{4'h4, dsf_pkg::DSF_SW_USER, 4'h2, 1'b1, 1, 4'hf, 1'b0},
        '{4'h4, dsf_pkg::DSF_SW_USER, 4'h2, 1'b1, 2, 4'h0, 1'b0},
        '{4'h4, dsf_pkg::DSF_SW_USER, 4'h9, 1'b1, 3, 4'h0, 1'b1}
    };

    always #10 mclk = ~mclk;

    dsf_top #(.NF(4)) u_dut (.mclk(mclk), .rst_b(rst_b),
        .scan_tick(scan_tick), .case_switch(case_switch),
        .detect(detect), .base_count(base_count), .ovr_en(ovr_en),
        .ovr_count(ovr_count), .sw_mode(sw_mode),
        .user_sw_count(user_sw_count), .alt_clear_en(alt_clear_en),
        .clear_count(clear_count), .safety_on(safety_on),
        .user_count_clamped(user_count_clamped));
    dsf_machine_ctrl #(.NF(4)) u_mc (.mclk(mclk), .rst_b(rst_b),
        .safety_on(safety_on), .run_ok(run_ok));

    // ==========================================================
    // Tasks
    // ==========================================================
    // Compare and count; x never passes
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
    endtask
    // k back-to-back scans with one detect pattern
    task automatic scans(input int k, input logic [3:0] d);
        @(posedge mclk);
        scan_tick <= 1'b1;
        detect    <= d;
        repeat (k) @(posedge mclk);
        scan_tick <= 1'b0;
    endtask
    // Outputs hold at the deciding scan edge and move one edge later
    task automatic latency(input logic [3:0] prev, input logic [3:0] e);
        #1 chk(safety_on, prev);
        @(posedge mclk);
        #1 chk(safety_on, e);
    endtask
    // Case switch pulse; scans follow so the case is held long enough
    task automatic swp();
        @(posedge mclk);
        case_switch <= 1'b1;
        @(posedge mclk);
        case_switch <= 1'b0;
    endtask
    // Four clear scans bring every field back ON
    task automatic restore();
        scans(4, 4'h0);
        tick(3);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Hang guard
    // ==========================================================
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        rst_b = 1'b0; scan_tick = 1'b0; case_switch = 1'b0;
        detect = 4'h0; base_count = 4'h2; ovr_en = 4'h0;
        ovr_count = 16'h0000; sw_mode = dsf_pkg::DSF_SW_FAST;
        user_sw_count = 4'h0; alt_clear_en = 1'b0; clear_count = 16'h0000;
        tick(16);
        #1 chk(safety_on, 4'h0);
        chk(user_count_clamped, 1'b0);
        tick(1);
        rst_b <= 1'b1;
        // Fields start tripped: three clear scans are not enough
        scans(3, 4'h0);
        tick(3);
        #1 chk(safety_on, 4'h0);
        scans(1, 4'h0);
        latency(4'h0, 4'hf);
        tick(1);
        $display("reset test done");
        // Table rows, every one starting with all fields ON
        foreach (rows[i]) begin
            base_count    <= rows[i].n;
            sw_mode       <= rows[i].m;
            user_sw_count <= rows[i].u;
            tick(2);
            if (rows[i].sw) begin
                swp();
            end
            scans(rows[i].k, 4'hf);
            latency(4'hf, rows[i].e);
            tick(1);
            #1 chk(run_ok, &rows[i].e);
            chk(user_count_clamped, rows[i].c);
            restore();
            $display("row %0d done", i);
        end
        // Broken clear run starts the four clear scans again
        base_count <= 4'h2;
        sw_mode    <= dsf_pkg::DSF_SW_FAST;
        scans(2, 4'hf);
        scans(3, 4'h0);
        tick(3);
        #1 chk(safety_on, 4'h0);
        scans(1, 4'hf);
        scans(3, 4'h0);
        tick(3);
        #1 chk(safety_on, 4'h0);
        scans(1, 4'h0);
        latency(4'h0, 4'hf);
        // Broken detection run starts the count again
        base_count <= 4'h3;
        scans(2, 4'hf);
        scans(1, 4'h0);
        scans(2, 4'hf);
        tick(3);
        #1 chk(safety_on, 4'hf);
        scans(1, 4'hf);
        latency(4'hf, 4'h0);
        restore();
        $display("restart test done");
        // Switch mid-count restarts detection: reliable count is two
        sw_mode <= dsf_pkg::DSF_SW_RELIABLE;
        scans(2, 4'hf);
        swp();
        scans(1, 4'hf);
        tick(3);
        #1 chk(safety_on, 4'hf);
        scans(1, 4'hf);
        latency(4'hf, 4'h0);
        restore();
        $display("switch restart test done");
        // Switch and scan on one edge: that scan uses the count of one
        sw_mode <= dsf_pkg::DSF_SW_FAST;
        @(posedge mclk);
        case_switch <= 1'b1;
        scan_tick   <= 1'b1;
        detect      <= 4'hf;
        @(posedge mclk);
        case_switch <= 1'b0;
        scan_tick   <= 1'b0;
        latency(4'hf, 4'h0);
        restore();
        sw_mode <= dsf_pkg::DSF_SW_RELIABLE;
        $display("same edge switch test done");
        // Field overrides: field 1 count one, field 0 count zero as one
        ovr_en    <= 4'h3;
        ovr_count <= 16'h0010;
        scans(1, 4'hf);
        latency(4'hf, 4'hc);
        restore();
        ovr_en <= 4'h0;
        $display("override test done");
        // Per-field clear counts 1, 2, 0 as 1 and 6
        alt_clear_en <= 1'b1;
        clear_count  <= 16'h6021;
        base_count   <= 4'h1;
        scans(1, 4'hf);
        tick(3);
        scans(1, 4'h0);
        latency(4'h0, 4'h5);
        scans(1, 4'h0);
        latency(4'h5, 4'h7);
        scans(3, 4'h0);
        tick(3);
        #1 chk(safety_on, 4'h7);
        scans(1, 4'h0);
        latency(4'h7, 4'hf);
        alt_clear_en <= 1'b0;
        $display("clear count test done");
        // Reset in mid-run with the clamp flag raised
        base_count    <= 4'h4;
        sw_mode       <= dsf_pkg::DSF_SW_USER;
        user_sw_count <= 4'h9;
        tick(3);
        #1 chk(user_count_clamped, 1'b1);
        tick(1);
        rst_b <= 1'b0;
        tick(2);
        #1 chk(safety_on, 4'h0);
        chk(user_count_clamped, 1'b0);
        tick(1);
        rst_b <= 1'b1;
        restore();
        #1 chk(safety_on, 4'hf);
        $display("mid-run reset test done");
        final_report();
    end
endmodule
`default_nettype wire
